// ### dv/hsc_board_ctl_tb.sv
// hot-swap board control: self-checking bench
// assumes hsc_partner plays the card power sequencer and the host
`timescale 1ns/100ps
module hsc_board_ctl_tb;
  localparam int NTF = 0;
  localparam int LMP = 1;
  localparam int PBR = 2;
  localparam int SBR = 3;
  localparam int PAD = 4;
  localparam int RCV = 5;
  localparam int WPI = 6;
  localparam int ARR = 7;
  localparam int REM = 8;
  localparam int LOC = 9;
  localparam int LCK = 10;
  localparam int RTY = 11;
  localparam int WID = 12;
  typedef struct {int sel; logic exp;} hsc_note_type;

  logic clock, rst, ejector, senseN, eepromPres, bootSrc, powerReq, ackEnable;
  logic lampWr, lampVal, cfgAcc, pgoodN, porN, pllLk, clrA, clrR;
  logic [3:0] ackDelay;
  logic [15:0] lfsrState;
  hsc_pkg::hsc_pins_type pins;
  hsc_pkg::hsc_host_cmd_type hostCmd;
  hsc_pkg::hsc_card_cmd_type cardCmd;
  logic eventNotifyOut, eventNotifyOeN, statusLampOut, statusLampOeN;
  logic procbusResetOutN, secondaryBusResetN, padEnable, receiverEnable;
  logic eepromLoadStart, waitProcInit, arrivalFlag, removalFlag, lampOnCtl;
  logic configLockout, cfgRetry, wideBackplanePresent, notifyWire, lampWire;
  logic [12:0] obs;
  hsc_note_type notes[$];
  hsc_note_type cur;
  int num_errors = 0;
  int checked = 0;
  int loadStarts = 0;
  string names [13] = '{"notify", "lamp", "pbReset", "sbReset", "pad", "receiver",
    "waitInit", "arrival", "removal", "lampCtl", "lockout", "retry", "wide"};

  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  // open-drain lines with pull-ups
  assign notifyWire = eventNotifyOeN ? 1'h1 : eventNotifyOut;
  assign lampWire = statusLampOeN ? 1'h1 : statusLampOut;
  assign pins = {ejector, pgoodN, senseN, porN, pllLk, eepromPres, bootSrc};
  assign hostCmd = {clrA, clrR, lampWr, lampVal, cfgAcc};
  assign obs = {wideBackplanePresent, cfgRetry, configLockout, lampOnCtl, removalFlag,
    arrivalFlag, waitProcInit, receiverEnable, padEnable, secondaryBusResetN,
    procbusResetOutN, lampWire, notifyWire};

  hsc_board_ctl hsc_board_ctl_inst (.clock(clock), .rst(rst), .pins(pins),
    .hostCmd(hostCmd), .cardCmd(cardCmd), .eventNotifyOut(eventNotifyOut),
    .eventNotifyOeN(eventNotifyOeN), .statusLampOut(statusLampOut),
    .statusLampOeN(statusLampOeN), .procbusResetOutN(procbusResetOutN),
    .secondaryBusResetN(secondaryBusResetN), .padEnable(padEnable),
    .receiverEnable(receiverEnable), .eepromLoadStart(eepromLoadStart),
    .waitProcInit(waitProcInit), .arrivalFlag(arrivalFlag), .removalFlag(removalFlag),
    .lampOnCtl(lampOnCtl), .configLockout(configLockout), .cfgRetry(cfgRetry),
    .wideBackplanePresent(wideBackplanePresent));

  hsc_partner hsc_partner_inst (.clock(clock), .powerReq(powerReq),
    .ackEnable(ackEnable), .ackDelay(ackDelay), .notifyLevel(notifyWire),
    .arrivalFlag(arrivalFlag), .removalFlag(removalFlag),
    .backendPowerGoodN(pgoodN), .poweronResetInN(porN), .pllLocked(pllLk),
    .clrArrival(clrA), .clrRemoval(clrR));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic note(input int sel, input logic exp);
    notes.push_back('{sel, exp});
  endtask

  task automatic check(input string name, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic pulseCard(input int b);
    cardCmd[b] = 1'h1;
    tick(1);
    cardCmd = 4'h0;
  endtask

  task automatic cfgPulse(input logic exp);
    cfgAcc = 1'h1;
    tick(1);
    note(RTY, exp);
    cfgAcc = 1'h0;
  endtask

  task automatic stop_test();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // monitor
  // ----------------------------------------------------------------
  // compares noted expectations at the falling edge
  always @(negedge clock) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(names[cur.sel], obs[cur.sel], cur.exp);
    end
    if (eepromLoadStart === 1'h1) loadStarts++;
  end

  // watchdog
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'h1;
    {ejector, senseN, eepromPres, bootSrc, powerReq, ackEnable} = 6'h0;
    {lampWr, lampVal, cfgAcc} = 3'h0;
    ackDelay = 4'h0;
    cardCmd = 4'h0;
    lfsrState = 16'hC23E;
    tick(3);
    rst = 1'h0;
    tick(4);
    note(NTF, 1'h1);
    note(LMP, 1'h0);
    note(PAD, 1'h0);
    note(RCV, 1'h0);
    note(PBR, 1'h0);
    note(LCK, 1'h1);
    tick(2);
    // three power-ups: EEPROM load, processor init, primary boot
    for (int i = 0; i < 3; i++) begin
      eepromPres = (i == 0);
      bootSrc = (i == 2);
      lfsrState = lfsr(lfsrState);
      senseN = lfsrState[0];
      ackDelay = lfsrState[4:1];
      powerReq = 1'h1;
      tick(24);
      note(LMP, 1'h1);
      note(PAD, 1'h1);
      note(RCV, 1'h1);
      note(PBR, 1'h1);
      note(SBR, 1'h1);
      note(WPI, i != 0);
      note(LCK, i != 2);
      check("loadStarts", loadStarts == 1, 1'h1);
      if (i == 1) begin
        cfgPulse(1'h1);
        pulseCard(0);
        tick(2);
        note(LCK, 1'h0);
      end else if (i == 0) begin
        pulseCard(2);
        tick(2);
        note(LCK, 1'h0);
      end
      cfgPulse(1'h0);
      pulseCard(i == 0 ? 3 : 1);
      tick(3);
      ejector = 1'h1;
      tick(5);
      note(ARR, 1'h1);
      note(NTF, 1'h0);
      tick(1);
      ackEnable = 1'h1;
      tick(24);
      note(ARR, 1'h0);
      note(NTF, 1'h1);
      ackEnable = 1'h0;
      ejector = 1'h0;
      tick(5);
      note(REM, 1'h1);
      note(NTF, 1'h0);
      tick(1);
      ackEnable = 1'h1;
      tick(24);
      note(REM, 1'h0);
      note(NTF, 1'h1);
      ackEnable = 1'h0;
      // card is idle now, host lights the lamp
      lampVal = 1'h1;
      lampWr = 1'h1;
      tick(1);
      lampWr = 1'h0;
      tick(2);
      note(LOC, 1'h1);
      note(LMP, 1'h0);
      ejector = 1'h1;
      tick(5);
      note(ARR, 1'h1);
      note(WID, !senseN);
      check("loadStarts", loadStarts == 1, 1'h1);
      tick(1);
      powerReq = 1'h0;
      tick(5);
      note(LMP, 1'h0);
      note(PAD, 1'h0);
      note(PBR, 1'h0);
      note(SBR, 1'h0);
      note(ARR, 1'h0);
      note(LOC, 1'h0);
      note(LCK, 1'h1);
      note(NTF, 1'h1);
      ejector = 1'h0;
      tick(4);
    end
    stop_test();
  end
endmodule

// ### dv/hsc_partner.sv
// hot-swap board control: card power sequencer and backplane host model
// assumes the bench raises powerReq to plug the card and gates host replies
`timescale 1ns/100ps
module hsc_partner (
  input wire logic clock,
  input wire logic powerReq,
  input wire logic ackEnable,
  input wire logic [3:0] ackDelay,
  input wire logic notifyLevel,
  input wire logic arrivalFlag,
  input wire logic removalFlag,
  output logic backendPowerGoodN,
  output logic poweronResetInN,
  output logic pllLocked,
  output logic clrArrival,
  output logic clrRemoval
);
  logic [3:0] seqCnt;
  logic [3:0] ackCnt;
  logic ackBusy;

  // ----------------------------------------------------------------
  // power sequencer
  // ----------------------------------------------------------------
  // staged ramp; losing power drops everything at once
  always @(posedge clock) begin
    if (!powerReq) begin
      seqCnt <= 4'h0;
    end else if (seqCnt != 4'hF) begin
      seqCnt <= seqCnt + 4'h1;
    end
  end
  assign backendPowerGoodN = !(powerReq && seqCnt >= 4'h3);
  assign poweronResetInN = powerReq && seqCnt >= 4'h7;
  assign pllLocked = powerReq && seqCnt >= 4'hA;

  // ----------------------------------------------------------------
  // host
  // ----------------------------------------------------------------
  initial begin
    clrArrival = 1'h0;
    clrRemoval = 1'h0;
    ackCnt = 4'h0;
    ackBusy = 1'h0;
  end

  // waits, reads both flags, clears the one behind the notify
  always @(posedge clock) begin
    clrArrival <= 1'h0;
    clrRemoval <= 1'h0;
    if (notifyLevel) begin
      ackCnt <= 4'h0;
      ackBusy <= 1'h0;
    end else if (ackEnable && !ackBusy) begin
      if (ackCnt < ackDelay) begin
        ackCnt <= ackCnt + 4'h1;
      end else begin
        clrRemoval <= removalFlag;
        clrArrival <= !removalFlag && arrivalFlag;
        ackBusy <= 1'h1;
      end
    end
  end
endmodule

// ### inc/hsc_pkg.sv
// hot-swap board control: shared constants, states and carriers
// assumes a single core clock and plain-port control from the bridge core
package hsc_pkg;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic HSC_LOCKOUT_RST = 1'h1;
  localparam logic HSC_FLAG_RST = 1'h0;
  localparam logic HSC_LAMP_CTL_RST = 1'h0;
  localparam logic HSC_ARMED_RST = 1'h0;
  localparam logic HSC_BOOT_RST = 1'h0;
  // boot source strap level that selects the primary bus
  localparam logic HSC_BOOT_PRIMARY = 1'h1;
  // ejector switch level meaning latch closed
  localparam logic HSC_LATCH_CLOSED = 1'h1;
  // synchroniser depth
  localparam int HSC_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HSC_OFF = 3'h0,
    HSC_POR_WAIT = 3'h1,
    HSC_PLL_WAIT = 3'h2,
    HSC_INIT_EE = 3'h3,
    HSC_INIT_PROC = 3'h4,
    HSC_RUN = 3'h5
  } hsc_state_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // asynchronous pin and strap inputs, synchronised as one group
  typedef struct packed {
    logic ejectorSwitchIn;
    logic backendPowerGoodN;
    logic wideBackplaneSenseN;
    logic poweronResetInN;
    logic pllLocked;
    logic eepromPresent;
    logic powerupBootSource;
  } hsc_pins_type;

  // one-cycle commands from the host-facing configuration logic
  typedef struct packed {
    logic clrArrival;
    logic clrRemoval;
    logic lampWrite;
    logic lampValue;
    logic cfgAccess;
  } hsc_host_cmd_type;

  // one-cycle commands from the card side
  typedef struct packed {
    logic eepromLoadDone;
    logic eepromLockoutWrite;
    logic procInitDone;
    logic procbusLockoutWrite;
  } hsc_card_cmd_type;

endpackage

// ### rtl/hsc_board_ctl.sv
// hot-swap board control: power sequencing, flags, lamp and lockout
// assumes pins arrive asynchronously, commands arrive on the core clock
//
// Function
// - lamp driven low while back-end power-good is negated
// - ejector input low means latch open, high means closed
// - power-good negated: pads disabled except lamp, receivers inhibited
// - power-good negated: all internal state held in reset
// - power-good asserted: lamp released, pads on, bus resets asserted
// - after power-on reset release wait PLL lock, then release bus resets
// - out of reset: run EEPROM load or wait for processor init
// - after init wait for closed switch, set arrival flag, assert notify
// - lockout resets to one; while set host config accesses are retried
// - host clears arrival flag; notify released when flag cleared
// - lockout cleared by EEPROM load write or processor-bus write
// - boot source set to primary bus clears lockout automatically
// - switch opening sets removal flag and asserts notify
// - clearing removal flag releases notify and arms arrival flag
// - lamp control bit set by software drives lamp low
// - re-closure or extraction after lamp lit never reloads from EEPROM
// - wide-backplane sense input, active low, reported to the core
`timescale 1ns/100ps
module hsc_board_ctl (
  input wire logic clock,
  input wire logic rst,
  input wire hsc_pkg::hsc_pins_type pins,
  input wire hsc_pkg::hsc_host_cmd_type hostCmd,
  input wire hsc_pkg::hsc_card_cmd_type cardCmd,
  output logic eventNotifyOut,
  output logic eventNotifyOeN,
  output logic statusLampOut,
  output logic statusLampOeN,
  output logic procbusResetOutN,
  output logic secondaryBusResetN,
  output logic padEnable,
  output logic receiverEnable,
  output logic eepromLoadStart,
  output logic waitProcInit,
  output logic arrivalFlag,
  output logic removalFlag,
  output logic lampOnCtl,
  output logic configLockout,
  output logic cfgRetry,
  output logic wideBackplanePresent
);

  // ----------------------------------------------------------------
  // synchronised pins
  // ----------------------------------------------------------------
  hsc_pkg::hsc_pins_type pinsIn;
  hsc_pkg::hsc_pins_type syncPins;
  logic pwrGood;
  logic latchClosed;
  logic latchClosedPrev_ff;

  // power-good enters inverted so cleared flops read as unpowered, no false power-up
  always_comb begin
    pinsIn = pins;
    pinsIn.backendPowerGoodN = !pins.backendPowerGoodN;
  end

  // all pins and straps pass two flops
  hsc_sync2 #(
    .WIDTH($bits(hsc_pkg::hsc_pins_type))
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din(pinsIn),
    .dout(syncPins)
  );

  assign pwrGood = syncPins.backendPowerGoodN; // field holds the good level here
  assign latchClosed = (syncPins.ejectorSwitchIn == hsc_pkg::HSC_LATCH_CLOSED);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hsc_pkg::hsc_state_type state_ff;
  hsc_pkg::hsc_state_type nxt_state;
  logic arrival_ff;
  logic removal_ff;
  logic armed_ff;
  logic lampCtl_ff;
  logic lockout_ff;
  logic bootPrimary_ff;
  logic nxt_arrival;
  logic nxt_removal;
  logic setArrival;
  logic setRemoval;
  logic nxt_lockout;

  // power-up and init sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hsc_pkg::HSC_OFF: begin
        nxt_state = hsc_pkg::HSC_POR_WAIT;
      end
      hsc_pkg::HSC_POR_WAIT: begin
        if (syncPins.poweronResetInN) begin
          nxt_state = hsc_pkg::HSC_PLL_WAIT;
        end
      end
      hsc_pkg::HSC_PLL_WAIT: begin
        if (!syncPins.poweronResetInN) begin
          nxt_state = hsc_pkg::HSC_POR_WAIT;
        end else if (syncPins.pllLocked) begin
          // eeprom load or processor init
          nxt_state = syncPins.eepromPresent ? hsc_pkg::HSC_INIT_EE
                                             : hsc_pkg::HSC_INIT_PROC;
        end
      end
      hsc_pkg::HSC_INIT_EE: begin
        if (cardCmd.eepromLoadDone) begin
          nxt_state = hsc_pkg::HSC_RUN;
        end
      end
      hsc_pkg::HSC_INIT_PROC: begin
        if (cardCmd.procInitDone) begin
          nxt_state = hsc_pkg::HSC_RUN;
        end
      end
      hsc_pkg::HSC_RUN: begin
        nxt_state = hsc_pkg::HSC_RUN;
      end
      default: begin
        nxt_state = hsc_pkg::HSC_OFF;
      end
    endcase
    if (!pwrGood) begin
      nxt_state = hsc_pkg::HSC_OFF;
    end
  end

  // sequencer register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= hsc_pkg::HSC_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // boot source strap caught once the PLLs lock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bootPrimary_ff <= hsc_pkg::HSC_BOOT_RST;
    end else if (!pwrGood) begin
      bootPrimary_ff <= hsc_pkg::HSC_BOOT_RST;
    end else if (state_ff == hsc_pkg::HSC_PLL_WAIT && syncPins.pllLocked) begin
      bootPrimary_ff <= (syncPins.powerupBootSource == hsc_pkg::HSC_BOOT_PRIMARY);
    end
  end

  // ----------------------------------------------------------------
  // insertion and extraction flags
  // ----------------------------------------------------------------
  // arrival needs arming, a closed latch and a finished init
  assign setArrival = armed_ff && latchClosed && state_ff == hsc_pkg::HSC_RUN;
  // opening edge of the latch once running
  assign setRemoval = latchClosedPrev_ff && !latchClosed
                      && state_ff == hsc_pkg::HSC_RUN;
  // set wins over a clear in the same cycle
  assign nxt_arrival = setArrival || (arrival_ff && !hostCmd.clrArrival);
  assign nxt_removal = setRemoval || (removal_ff && !hostCmd.clrRemoval);

  // latch history for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latchClosedPrev_ff <= 1'h0;
    end else begin
      latchClosedPrev_ff <= latchClosed && pwrGood;
    end
  end

  // flag registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arrival_ff <= hsc_pkg::HSC_FLAG_RST;
      removal_ff <= hsc_pkg::HSC_FLAG_RST;
    end else if (!pwrGood) begin
      arrival_ff <= hsc_pkg::HSC_FLAG_RST;
      removal_ff <= hsc_pkg::HSC_FLAG_RST;
    end else begin
      arrival_ff <= nxt_arrival;
      removal_ff <= nxt_removal;
    end
  end

  // arming: on init finish, and on removal flag cleared
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_ff <= hsc_pkg::HSC_ARMED_RST;
    end else if (!pwrGood) begin
      armed_ff <= hsc_pkg::HSC_ARMED_RST;
    end else if (state_ff != hsc_pkg::HSC_RUN && nxt_state == hsc_pkg::HSC_RUN) begin
      armed_ff <= 1'h1;
    end else if (removal_ff && hostCmd.clrRemoval && !setRemoval) begin
      armed_ff <= 1'h1;
    end else if (setArrival) begin
      armed_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // lamp control and configuration lockout
  // ----------------------------------------------------------------
  // software lamp bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lampCtl_ff <= hsc_pkg::HSC_LAMP_CTL_RST;
    end else if (!pwrGood) begin
      lampCtl_ff <= hsc_pkg::HSC_LAMP_CTL_RST;
    end else if (hostCmd.lampWrite) begin
      lampCtl_ff <= hostCmd.lampValue;
    end
  end

  // lockout clears from eeprom, processor bus or primary boot
  always_comb begin
    nxt_lockout = lockout_ff;
    if (cardCmd.eepromLockoutWrite || cardCmd.procbusLockoutWrite) begin
      nxt_lockout = 1'h0;
    end
    if (bootPrimary_ff && state_ff != hsc_pkg::HSC_OFF
        && state_ff != hsc_pkg::HSC_POR_WAIT && state_ff != hsc_pkg::HSC_PLL_WAIT) begin
      nxt_lockout = 1'h0;
    end
  end

  // lockout register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lockout_ff <= hsc_pkg::HSC_LOCKOUT_RST;
    end else if (!pwrGood) begin
      lockout_ff <= hsc_pkg::HSC_LOCKOUT_RST;
    end else begin
      lockout_ff <= nxt_lockout;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic notifyOeN_ff;
  logic lampOeN_ff;
  logic pbRstN_ff;
  logic secRstN_ff;
  logic pads_ff;
  logic eeStart_ff;
  logic waitProc_ff;
  logic retry_ff;
  logic wide_ff;

  // pad, lamp and notify drive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pads_ff <= 1'h0;
      lampOeN_ff <= 1'h0;
      notifyOeN_ff <= 1'h1;
    end else begin
      pads_ff <= pwrGood;
      lampOeN_ff <= !(!pwrGood || lampCtl_ff);
      notifyOeN_ff <= !(pwrGood && (nxt_arrival || nxt_removal));
    end
  end

  // bus resets follow the sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pbRstN_ff <= 1'h0;
      secRstN_ff <= 1'h0;
    end else begin
      pbRstN_ff <= pwrGood && (state_ff == hsc_pkg::HSC_INIT_EE
                  || state_ff == hsc_pkg::HSC_INIT_PROC
                  || state_ff == hsc_pkg::HSC_RUN);
      secRstN_ff <= pwrGood && (state_ff == hsc_pkg::HSC_INIT_EE
                  || state_ff == hsc_pkg::HSC_INIT_PROC
                  || state_ff == hsc_pkg::HSC_RUN);
    end
  end

  // init handshakes; eeprom start only on entry from the pll wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      eeStart_ff <= 1'h0;
      waitProc_ff <= 1'h0;
    end else begin
      eeStart_ff <= state_ff == hsc_pkg::HSC_PLL_WAIT
                    && nxt_state == hsc_pkg::HSC_INIT_EE;
      waitProc_ff <= nxt_state == hsc_pkg::HSC_INIT_PROC;
    end
  end

  // config retry and backplane sense
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      retry_ff <= 1'h0;
      wide_ff <= 1'h0;
    end else begin
      retry_ff <= pwrGood && hostCmd.cfgAccess && lockout_ff;
      wide_ff <= pwrGood && !syncPins.wideBackplaneSenseN;
    end
  end

  assign eventNotifyOut = notifyOeN_ff;
  assign eventNotifyOeN = notifyOeN_ff;
  assign statusLampOut = lampOeN_ff;
  assign statusLampOeN = lampOeN_ff;
  assign procbusResetOutN = pbRstN_ff;
  assign secondaryBusResetN = secRstN_ff;
  assign padEnable = pads_ff;
  assign receiverEnable = pads_ff;
  assign eepromLoadStart = eeStart_ff;
  assign waitProcInit = waitProc_ff;
  assign arrivalFlag = arrival_ff;
  assign removalFlag = removal_ff;
  assign lampOnCtl = lampCtl_ff;
  assign configLockout = lockout_ff;
  assign cfgRetry = retry_ff;
  assign wideBackplanePresent = wide_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_pll_locks;
    state_ff == hsc_pkg::HSC_PLL_WAIT && syncPins.pllLocked
    && syncPins.poweronResetInN && pwrGood;
  endsequence

  sequence s_resets_released;
    procbusResetOutN && secondaryBusResetN;
  endsequence

  property p_lamp_unpowered;
    !pwrGood |=> !statusLampOeN && !statusLampOut;
  endproperty
  a_lamp_unpowered: assert property (p_lamp_unpowered)
    else $error("lamp not driven while power-good negated");

  property p_pads_off;
    !pwrGood |=> !padEnable && !receiverEnable && eventNotifyOeN;
  endproperty
  a_pads_off: assert property (p_pads_off)
    else $error("pads active while power-good negated");

  property p_state_reset;
    !pwrGood |=> !arrivalFlag && !removalFlag && configLockout && !lampOnCtl;
  endproperty
  a_state_reset: assert property (p_state_reset)
    else $error("internal state not reset without power-good");

  property p_power_up;
    $rose(pwrGood) |=> padEnable && !procbusResetOutN && !secondaryBusResetN;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("power-up did not enable pads with resets held");

  property p_pll_release;
    s_pll_locks ##1 pwrGood |=> s_resets_released;
  endproperty
  a_pll_release: assert property (p_pll_release)
    else $error("bus resets not released after pll lock");

  property p_hold_unlocked;
    state_ff == hsc_pkg::HSC_PLL_WAIT && !syncPins.pllLocked |=> !procbusResetOutN;
  endproperty
  a_hold_unlocked: assert property (p_hold_unlocked)
    else $error("bus reset released before pll lock");

  property p_arrival;
    setArrival && pwrGood |=> arrivalFlag && !eventNotifyOeN;
  endproperty
  a_arrival: assert property (p_arrival)
    else $error("closed latch did not raise arrival and notify");

  property p_removal;
    setRemoval && pwrGood |=> removalFlag && !eventNotifyOeN;
  endproperty
  a_removal: assert property (p_removal)
    else $error("opened latch did not raise removal and notify");

  property p_retry;
    configLockout && hostCmd.cfgAccess && pwrGood |=> cfgRetry;
  endproperty
  a_retry: assert property (p_retry)
    else $error("config access not retried under lockout");

  property p_lockout_clear;
    pwrGood && cardCmd.procbusLockoutWrite |=> !configLockout;
  endproperty
  a_lockout_clear: assert property (p_lockout_clear)
    else $error("processor-bus write did not clear lockout");

  property p_lamp_soft;
    pwrGood && lampOnCtl |=> !statusLampOeN;
  endproperty
  a_lamp_soft: assert property (p_lamp_soft)
    else $error("lamp control bit did not light the lamp");

  property p_no_reload;
    state_ff == hsc_pkg::HSC_RUN |=> !eepromLoadStart;
  endproperty
  a_no_reload: assert property (p_no_reload)
    else $error("eeprom reload started while running");

  property p_notify_release;
    pwrGood && !setArrival && !setRemoval && (hostCmd.clrArrival || !arrivalFlag)
    && (hostCmd.clrRemoval || !removalFlag) |=> eventNotifyOeN;
  endproperty
  a_notify_release: assert property (p_notify_release)
    else $error("notify held after both flags cleared");

endmodule

// ### rtl/hsc_sync2.sv
// hot-swap board control: two-flop synchroniser for a group of levels
// assumes inputs are quasi-static compared with the core clock
`timescale 1ns/100ps
module hsc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // ----------------------------------------------------------------
  // two stages; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end

  assign dout = stage2_ff;

endmodule
